// ==== sns_neg_sel.sv ====
/*
 * Sequencer negative-input select register for analog inputs 0 to 11.
 * Software writes and reads it over a plain register port; when the
 * sequencer starts a conversion on one of these inputs, that input's
 * field is decoded and driven to the negative multiplexer.
 * Assumes the register port and the sequencer share CORE_CLK, so no
 * synchronisers are needed; inputs 12 to 15 are served elsewhere.
 */
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sns_params.svh"

// Function
// - 32-bit register at fixed address, reserved zero
// - Field applied only when its input converts
// - Input 11 select in bit 29
// - Input 9 select in bit 24
// - Input 10 select in bits 28:25
// - Input 8 select in bits 23:20
// - Input 6 select in bits 18:15
// - Common four-bit decode, high codes negative reference
// - Input 2 select in bits 8:5
// - Fields read-write, reset to zero
module sns_neg_sel (
    // Clock and reset.
    input wire logic CORE_CLK,
    input wire logic SRST,
    // Register port.
    input wire logic [31:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Sequencer conversion request.
    input wire logic SEQ_CONV_START,
    input wire logic [3:0] SEQ_POS_CH,
    // Negative multiplexer control.
    output logic [3:0] NEG_MUX_SEL,
    output logic NEG_MUX_VALID,
    output logic NEG_MUX_MISS
);

    localparam int N = `SNS_NUM_INPUTS;
    // Least significant bit of each input's field in the register word.
    localparam int LSB [N] = '{
        `SNS_IN0_LSB,
        `SNS_IN1_LSB,
        `SNS_IN2_LSB,
        `SNS_IN3_LSB, `SNS_IN4_LSB, `SNS_IN5_LSB,
        `SNS_IN6_LSB,
        `SNS_IN7_LSB,
        `SNS_IN8_LSB,
        `SNS_IN9_LSB,
        `SNS_IN10_LSB,
        `SNS_IN11_LSB
    };

    sns_pkg::sns_state_t state_q;
    sns_pkg::sns_state_t state_d;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] reg_word;
    sns_pkg::sns_src_t dec [N];

    // Address decode of the register port.
    sns_bus_dec u_bus_dec (
        .addr(REG_ADDR),
        .wr(REG_WR),
        .rd(REG_RD),
        .wr_hit(wr_hit),
        .rd_hit(rd_hit)
    );

    // Full register word with the reserved bits forced to zero.
    assign reg_word = {2'b00, state_q.sel};

    // One decoder per input; even inputs are four bits, odd inputs one.
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_dec
            localparam int W = (gi % 2 == 0) ? `SNS_EVEN_W : `SNS_ODD_W;
            sns_field_dec #(
                .W(W)
            ) u_dec (
                .code(reg_word[LSB[gi] +: W]),
                .src(dec[gi])
            );
        end
    endgenerate

    // Next state: register writes, read data and multiplexer select.
    always_comb
    begin
        state_d = state_q;
        state_d.mux_valid = 1'b0;
        state_d.mux_miss = 1'b0;
        state_d.rdata = 32'h00000000;
        if (wr_hit)
        begin
            // Every field is writable; reserved bits are dropped.
            state_d.sel = REG_WDATA[`SNS_STORE_W-1:0];
        end
        if (rd_hit)
        begin
            state_d.rdata = reg_word;
        end
        if (SEQ_CONV_START)
        begin
            if (SEQ_POS_CH <= `SNS_LAST_INPUT)
            begin
                // The selected input's own field drives the multiplexer.
                state_d.mux_sel = dec[SEQ_POS_CH];
                state_d.mux_valid = 1'b1;
            end
            else
            begin
                // Inputs 12 to 15 belong to the companion register.
                state_d.mux_miss = 1'b1;
            end
        end
    end

    // State register with synchronous reset to all zeros.
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the state register.
    assign REG_RDATA = state_q.rdata;
    assign NEG_MUX_SEL = state_q.mux_sel;
    assign NEG_MUX_VALID = state_q.mux_valid;
    assign NEG_MUX_MISS = state_q.mux_miss;

    // Reference decode of a four-bit field, used by the checks below.
    function automatic logic [3:0] ref_dec4(input logic [3:0] c);
        logic [3:0] r;
        r = (c > 4'h9) ? 4'h0 : c;
        return r;
    endfunction

    // A conversion request on one of the covered inputs.
    sequence s_start(logic [3:0] ch);
        SEQ_CONV_START && (SEQ_POS_CH == ch);
    endsequence

    // A write to the register followed at once by a read of it.
    sequence s_wr_rd;
        wr_hit ##1 rd_hit;
    endsequence

    // Reserved bits always read zero.
    property p_rsvd_zero;
        @(posedge CORE_CLK) disable iff (SRST)
        rd_hit |=> (REG_RDATA[31:30] == 2'b00);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("Reserved bits read nonzero.");

    // Writes to any other address leave the register alone.
    property p_other_addr;
        @(posedge CORE_CLK) disable iff (SRST)
        (REG_WR && !wr_hit) |=> $stable(state_q.sel);
    endproperty
    a_other_addr: assert property (p_other_addr)
        else $error("Unmapped write changed the register.");

    // After reset the register reads zero and the mux shows the negative reference.
    property p_reset_zero;
        @(posedge CORE_CLK) disable iff (SRST)
        $fell(SRST) |-> (state_q.sel == 30'h0) && (NEG_MUX_SEL == 4'h0)
            && !NEG_MUX_VALID && (REG_RDATA == 32'h00000000);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("Register not zero after reset.");

    // A write reads back masked in the next read.
    property p_readback;
        logic [31:0] w;
        @(posedge CORE_CLK) disable iff (SRST)
        (wr_hit, w = REG_WDATA) ##1 rd_hit |=> (REG_RDATA == (w & `SNS_WR_MASK));
    endproperty
    a_readback: assert property (p_readback)
        else $error("Read back differs from written value.");

    // Back-to-back write and read keep the reserved bits clear.
    property p_wr_rd_rsvd;
        @(posedge CORE_CLK) disable iff (SRST)
        s_wr_rd |=> (REG_RDATA[31:30] == 2'b00);
    endproperty
    a_wr_rd_rsvd: assert property (p_wr_rd_rsvd)
        else $error("Reserved bits set after write.");

    // Without a start the multiplexer select does not move.
    property p_hold;
        @(posedge CORE_CLK) disable iff (SRST)
        !SEQ_CONV_START |=> $stable(NEG_MUX_SEL) && !NEG_MUX_VALID;
    endproperty
    a_hold: assert property (p_hold)
        else $error("Select changed without a conversion.");

    // Inputs above 11 are not applied here.
    property p_miss;
        @(posedge CORE_CLK) disable iff (SRST)
        (SEQ_CONV_START && SEQ_POS_CH > 4'hB)
            |=> NEG_MUX_MISS && !NEG_MUX_VALID && $stable(NEG_MUX_SEL);
    endproperty
    a_miss: assert property (p_miss)
        else $error("Input above 11 was applied.");

    // Input 11 uses bit 29.
    property p_in11;
        @(posedge CORE_CLK) disable iff (SRST)
        s_start(4'hB) |=> NEG_MUX_VALID && (NEG_MUX_SEL == {3'b000, $past(state_q.sel[29])});
    endproperty
    a_in11: assert property (p_in11)
        else $error("Input 11 select wrong.");

    // Input 9 uses bit 24.
    property p_in9;
        @(posedge CORE_CLK) disable iff (SRST)
        s_start(4'h9) |=> (NEG_MUX_SEL == {3'b000, $past(state_q.sel[24])});
    endproperty
    a_in9: assert property (p_in9)
        else $error("Input 9 select wrong.");

    // Input 10 uses bits 28 to 25.
    property p_in10;
        @(posedge CORE_CLK) disable iff (SRST)
        s_start(4'hA) |=> (NEG_MUX_SEL == ref_dec4($past(state_q.sel[28:25])));
    endproperty
    a_in10: assert property (p_in10)
        else $error("Input 10 select wrong.");

    // Input 8 uses bits 23 to 20.
    property p_in8;
        @(posedge CORE_CLK) disable iff (SRST)
        s_start(4'h8) |=> (NEG_MUX_SEL == ref_dec4($past(state_q.sel[23:20])));
    endproperty
    a_in8: assert property (p_in8)
        else $error("Input 8 select wrong.");

    // Input 6 uses bits 18 to 15.
    property p_in6;
        @(posedge CORE_CLK) disable iff (SRST)
        s_start(4'h6) |=> (NEG_MUX_SEL == ref_dec4($past(state_q.sel[18:15])));
    endproperty
    a_in6: assert property (p_in6)
        else $error("Input 6 select wrong.");

    // Input 2 uses bits 8 to 5.
    property p_in2;
        @(posedge CORE_CLK) disable iff (SRST)
        s_start(4'h2) |=> (NEG_MUX_SEL == ref_dec4($past(state_q.sel[8:5])));
    endproperty
    a_in2: assert property (p_in2)
        else $error("Input 2 select wrong.");

    // Input 4 uses bits 13 to 10.
    property p_in4;
        @(posedge CORE_CLK) disable iff (SRST)
        s_start(4'h4) |=> (NEG_MUX_SEL == ref_dec4($past(state_q.sel[13:10])));
    endproperty
    a_in4: assert property (p_in4)
        else $error("Input 4 select wrong.");

    // Odd inputs 7, 5 and 3 use bits 19, 14 and 9.
    property p_odd_low;
        @(posedge CORE_CLK) disable iff (SRST)
        (s_start(4'h7) |=> (NEG_MUX_SEL == {3'b000, $past(state_q.sel[19])}))
        and (s_start(4'h5) |=> (NEG_MUX_SEL == {3'b000, $past(state_q.sel[14])}))
        and (s_start(4'h3) |=> (NEG_MUX_SEL == {3'b000, $past(state_q.sel[9])}));
    endproperty
    a_odd_low: assert property (p_odd_low)
        else $error("Odd input select wrong.");

    // Codes 10 to 15 on any even field give the negative reference.
    property p_high_code;
        @(posedge CORE_CLK) disable iff (SRST)
        (SEQ_CONV_START && !SEQ_POS_CH[0] && SEQ_POS_CH <= 4'hB
            && reg_word[LSB[SEQ_POS_CH] +: 4] > 4'h9)
            |=> NEG_MUX_VALID && (NEG_MUX_SEL == 4'h0);
    endproperty
    a_high_code: assert property (p_high_code)
        else $error("High code did not select the negative reference.");

    // The select stands until the next applied conversion.
    property p_stand;
        @(posedge CORE_CLK) disable iff (SRST)
        NEG_MUX_VALID ##1 !SEQ_CONV_START[*2] |=> $stable(NEG_MUX_SEL);
    endproperty
    a_stand: assert property (p_stand)
        else $error("Select did not stand between conversions.");

    // Input 0 uses bits 3 to 0 with the common decode.
    property p_in0;
        @(posedge CORE_CLK) disable iff (SRST)
        s_start(4'h0) |=> (NEG_MUX_SEL == ref_dec4($past(state_q.sel[3:0])));
    endproperty
    a_in0: assert property (p_in0)
        else $error("Input 0 select wrong.");

    // Input 1 uses bit 4.
    property p_in1;
        @(posedge CORE_CLK) disable iff (SRST)
        s_start(4'h1) |=> (NEG_MUX_SEL == {3'b000, $past(state_q.sel[4])});
    endproperty
    a_in1: assert property (p_in1)
        else $error("Input 1 select wrong.");

    // Read data is zero in every cycle that does not answer a read.
    property p_rdata_idle;
        @(posedge CORE_CLK) disable iff (SRST)
        !rd_hit |=> (REG_RDATA == 32'h00000000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("Read data nonzero outside a read answer.");

    // A write to the register lands in the next cycle.
    property p_write_lands;
        @(posedge CORE_CLK) disable iff (SRST)
        wr_hit |=> (state_q.sel == $past(REG_WDATA[29:0]));
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("Register write did not land.");

    // A start on a covered input is applied one cycle later.
    property p_apply;
        @(posedge CORE_CLK) disable iff (SRST)
        (SEQ_CONV_START && SEQ_POS_CH <= 4'hB)
            |=> NEG_MUX_VALID && !NEG_MUX_MISS;
    endproperty
    a_apply: assert property (p_apply)
        else $error("Covered input was not applied.");

    // Valid and miss never stand together.
    property p_excl;
        @(posedge CORE_CLK) disable iff (SRST)
        !(NEG_MUX_VALID && NEG_MUX_MISS);
    endproperty
    a_excl: assert property (p_excl)
        else $error("Valid and miss high together.");

endmodule
`default_nettype wire

// ==== sns_params.svh ====
/*
 * Constants for the sequencer negative-input select register: its byte
 * address, reset value, field positions and widths, and the select codes.
 * Assumes it is included by bare name from the block's design files.
 */
`ifndef SNS_PARAMS_SVH
`define SNS_PARAMS_SVH

// Byte address and reset value of the select register.
`define SNS_REG_ADDR 32'h400680A0
`define SNS_REG_RESET 32'h00000000

// Bits that software may write; the top two are reserved and read zero.
`define SNS_WR_MASK 32'h3FFFFFFF
`define SNS_RSVD_MSB 31
`define SNS_RSVD_LSB 30
`define SNS_STORE_W 30

// Field widths: even inputs take four bits, odd inputs one bit.
`define SNS_EVEN_W 4
`define SNS_ODD_W 1

// Least significant bit of each input's field.
`define SNS_IN0_LSB 0
`define SNS_IN1_LSB 4
`define SNS_IN2_LSB 5
`define SNS_IN3_LSB 9
`define SNS_IN4_LSB 10
`define SNS_IN5_LSB 14
`define SNS_IN6_LSB 15
`define SNS_IN7_LSB 19
`define SNS_IN8_LSB 20
`define SNS_IN9_LSB 24
`define SNS_IN10_LSB 25
`define SNS_IN11_LSB 29

// Number of inputs this register covers and the select code limits.
`define SNS_NUM_INPUTS 12
`define SNS_LAST_INPUT 4'hB
`define SNS_CODE_LAST_AIN 4'h9

`endif

// ==== sns_pkg.sv ====
/*
 * Types shared by the negative-input select block: the normalised
 * negative source code and the packed state of the top module.
 * Assumes sns_params.svh is compiled alongside it.
 */
package sns_pkg;

    // Normalised source code driven to the negative multiplexer.
    typedef enum logic [3:0] {
        SNS_SRC_REFN = 4'h0,
        SNS_SRC_REFP = 4'h1,
        SNS_SRC_IN1 = 4'h2,
        SNS_SRC_IN3 = 4'h3,
        SNS_SRC_IN5 = 4'h4,
        SNS_SRC_IN7 = 4'h5,
        SNS_SRC_IN9 = 4'h6,
        SNS_SRC_IN11 = 4'h7,
        SNS_SRC_IN13 = 4'h8,
        SNS_SRC_IN15 = 4'h9
    } sns_src_t;

    // All state of the top module.
    typedef struct packed {
        logic [29:0] sel;
        logic [31:0] rdata;
        sns_src_t mux_sel;
        logic mux_valid;
        logic mux_miss;
    } sns_state_t;

endpackage

// ==== sns_field_dec.sv ====
/*
 * Decoder for one select field, one or four bits wide, into the
 * normalised source code. Purely combinational; the caller registers it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sns_params.svh"

module sns_field_dec #(
    parameter int W = 4
) (
    // Raw field from the select register.
    input wire logic [W-1:0] code,
    // Normalised source code.
    output var sns_pkg::sns_src_t src
);

    generate
        if (W == 1)
        begin : g_bit
            // A single bit picks between the two references.
            always_comb
            begin
                src = code[0] ? sns_pkg::SNS_SRC_REFP : sns_pkg::SNS_SRC_REFN;
            end
        end
        else
        begin : g_nib
            // Codes above the last odd input fall back to the negative reference.
            always_comb
            begin
                if (code[3:0] <= `SNS_CODE_LAST_AIN)
                begin
                    src = sns_pkg::sns_src_t'(code[3:0]);
                end
                else
                begin
                    src = sns_pkg::SNS_SRC_REFN;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ==== sns_bus_dec.sv ====
/*
 * Address decode for the select register on the plain register port.
 * Assumes strobes are one cycle long and never both high at once.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sns_params.svh"

module sns_bus_dec (
    // Register port request.
    input wire logic [31:0] addr,
    input wire logic wr,
    input wire logic rd,
    // Decoded strobes.
    output logic wr_hit,
    output logic rd_hit
);

    // Only the one fixed address is mapped.
    always_comb
    begin
        wr_hit = wr && (addr == `SNS_REG_ADDR);
        rd_hit = rd && (addr == `SNS_REG_ADDR);
    end

endmodule
`default_nettype wire

// ==== tb_top.sv ====
/*
 * Self-checking testbench for the sequencer negative-input select block.
 * Assumes sns_params.svh and sns_pkg.sv are compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sns_params.svh"

module tb_top;
    // Stimulus and observed signals.
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] reg_addr = 32'h00000000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic conv_start = 1'b0;
    logic [3:0] pos_ch = 4'h0;
    logic [3:0] mux_sel;
    logic mux_valid;
    logic mux_miss;
    int failures = 0;
    int compares = 0;
    logic [31:0] rd_val;

    // The clock runs at 20 MHz.
    always #25 core_clk = ~core_clk;

    sns_neg_sel u_sns_neg_sel (
        .CORE_CLK(core_clk),
        .SRST(srst),
        .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr),
        .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata),
        .SEQ_CONV_START(conv_start),
        .SEQ_POS_CH(pos_ch),
        .NEG_MUX_SEL(mux_sel),
        .NEG_MUX_VALID(mux_valid),
        .NEG_MUX_MISS(mux_miss)
    );

    // Compares one value and counts the outcome.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One-cycle register write.
    task automatic reg_write(input logic [31:0] addr, input logic [31:0] data);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle register read; data is taken in the following cycle.
    task automatic reg_read(input logic [31:0] addr, output logic [31:0] data);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        data = reg_rdata;
    endtask

    // Starts one conversion and judges the multiplexer answer.
    task automatic conv(input logic [3:0] ch, input logic [3:0] exp_sel);
        @(posedge core_clk);
        conv_start <= 1'b1;
        pos_ch <= ch;
        @(posedge core_clk);
        conv_start <= 1'b0;
        @(negedge core_clk);
        check("mux_sel", {28'h0, mux_sel}, {28'h0, exp_sel});
        check("mux_valid", {31'h0, mux_valid}, {31'h0, ch < 4'hC});
        check("mux_miss", {31'h0, mux_miss}, {31'h0, ch >= 4'hC});
    endtask

    // Expected source for input i from a register word.
    function automatic logic [3:0] exp_src(input int i, input logic [31:0] w);
        int lsb;
        logic [3:0] code;
        lsb = (i / 2) * 5 + (i % 2) * 4;
        code = (i % 2 == 1) ? {3'h0, w[lsb]} : w[lsb +: 4];
        exp_src = (code > 4'h9) ? 4'h0 : code;
    endfunction

    // Register and every input's select are zero after reset.
    task automatic t_reset_values();
        reg_read(`SNS_REG_ADDR, rd_val);
        check("reset_value", rd_val, 32'h00000000);
        for (int i = 0; i < 12; i++)
            conv(i[3:0], 4'h0);
    endtask

    // Reserved bits, an unmapped address and a read right after a write.
    task automatic t_reserved_unmapped();
        reg_write(`SNS_REG_ADDR, 32'hFFFFFFFF);
        reg_read(`SNS_REG_ADDR, rd_val);
        check("reserved_read", rd_val, 32'h3FFFFFFF);
        reg_write(`SNS_REG_ADDR + 32'h4, 32'h00000000);
        reg_read(`SNS_REG_ADDR, rd_val);
        check("unmapped_write", rd_val, 32'h3FFFFFFF);
        reg_read(`SNS_REG_ADDR + 32'h4, rd_val);
        check("unmapped_read", rd_val, 32'h00000000);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= `SNS_REG_ADDR;
        reg_wdata <= 32'h15A4B7D2;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check("write_then_read", reg_rdata, 32'h15A4B7D2);
        @(negedge core_clk);
        check("rdata_after", reg_rdata, 32'h00000000);
    endtask

    // Each input takes its own field for several words.
    task automatic t_field_map();
        logic [31:0] pats [3];
        pats = '{32'h3FFFFFFF, 32'h2AF13C69, 32'h15A4B7D2};
        foreach (pats[p])
        begin
            reg_write(`SNS_REG_ADDR, pats[p]);
            for (int i = 0; i < 12; i++)
                conv(i[3:0], exp_src(i, pats[p]));
        end
    endtask

    // Every four-bit code on inputs 10 and 8.
    task automatic t_decode();
        logic [31:0] w;
        for (int c = 0; c < 16; c++)
        begin
            w = (32'(c) << 25) | (32'(15 - c) << 20);
            reg_write(`SNS_REG_ADDR, w);
            conv(4'hA, (c > 9) ? 4'h0 : 4'(c));
            conv(4'h8, (15 - c > 9) ? 4'h0 : 4'(15 - c));
        end
    endtask

    // Select holds until a start, upper inputs miss, starts back to back.
    task automatic t_hold_and_miss();
        reg_write(`SNS_REG_ADDR, 32'h9 << 25);
        conv(4'hA, 4'h9);
        reg_write(`SNS_REG_ADDR, 32'h3 << 25);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        check("sel_held", {28'h0, mux_sel}, 32'h9);
        conv(4'hD, 4'h9);
        @(posedge core_clk);
        conv_start <= 1'b1;
        pos_ch <= 4'hC;
        @(posedge core_clk);
        pos_ch <= 4'hA;
        @(negedge core_clk);
        check("b2b_miss", {31'h0, mux_miss}, 32'h1);
        check("b2b_sel_kept", {28'h0, mux_sel}, 32'h9);
        @(posedge core_clk);
        conv_start <= 1'b0;
        @(negedge core_clk);
        check("b2b_valid", {31'h0, mux_valid}, 32'h1);
        check("b2b_sel_new", {28'h0, mux_sel}, 32'h3);
        @(negedge core_clk);
        check("valid_one_cycle", {31'h0, mux_valid}, 32'h0);
    endtask

    // A reset in mid-run clears the register again.
    task automatic t_mid_reset();
        reg_write(`SNS_REG_ADDR, 32'h2AF13C69);
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        reg_read(`SNS_REG_ADDR, rd_val);
        check("mid_reset_value", rd_val, 32'h00000000);
        conv(4'h4, 4'h0);
    endtask

    // Main sequence.
    initial
    begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        t_reset_values();
        t_reserved_unmapped();
        t_field_map();
        t_decode();
        t_hold_and_miss();
        t_mid_reset();
        test_done();
    end

    // Cuts a hung run short.
    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        test_done();
    end
endmodule

`default_nettype wire
